/* gpr_input_sync.sv */
// Multi-stage synchroniser for the pad input levels
`timescale 1ns/1ps
module gpr_input_sync #(
  parameter int WIDTH = 16,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pad levels in, synchronised levels out
  gpr_sync_if.syncer sync
);

  logic [WIDTH-1:0] stage_reg [STAGES];
  logic [WIDTH-1:0] stage_next [STAGES];

  if (STAGES < 2) begin : g_stageCheck
    $error("gpr_input_sync needs at least two stages");
  end

  always_comb begin
    stage_next[0] = sync.padLevel;
    for (int i = 1; i < STAGES; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= stage_next[i];
      end
    end
  end

  assign sync.sampled = stage_reg[STAGES-1];

endmodule : gpr_input_sync

/* gpr_pkg.sv */
// Shared constants, register map and state codes of the port register set
package gpr_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CONFIG_LOW = 5'h00;
  localparam logic [4:0] OFS_CONFIG_HIGH = 5'h04;
  localparam logic [4:0] OFS_INPUT_SAMPLE = 5'h08;
  localparam logic [4:0] OFS_OUTPUT_LATCH = 5'h0C;
  localparam logic [4:0] OFS_ATOMIC_SET_CLEAR = 5'h10;
  localparam logic [4:0] OFS_ATOMIC_CLEAR = 5'h14;
  localparam logic [4:0] OFS_CONFIG_FREEZE = 5'h18;

  // Reset values
  localparam logic [31:0] RST_CONFIG_LOW = 32'h4444_4444;
  localparam logic [31:0] RST_CONFIG_HIGH = 32'h4444_4444;
  localparam logic [15:0] RST_OUTPUT_LATCH = 16'h0000;
  localparam logic [15:0] RST_FREEZE_BITS = 16'h0000;

  // Field positions
  localparam int NIBBLE_W = 4;
  localparam int DIR_SPEED_LSB = 0;
  localparam int STYLE_LSB = 2;
  localparam int FREEZE_KEY_BIT = 16;
  localparam int CLEAR_REQ_LSB = 16;

  // Direction and speed field codes
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_OUT_10MHZ = 2'h1;
  localparam logic [1:0] DIR_OUT_2MHZ = 2'h2;
  localparam logic [1:0] DIR_OUT_50MHZ = 2'h3;

  // Style field codes, input mode
  localparam logic [1:0] STYLE_IN_ANALOG = 2'h0;
  localparam logic [1:0] STYLE_IN_FLOATING = 2'h1;
  localparam logic [1:0] STYLE_IN_PULL = 2'h2;
  localparam logic [1:0] STYLE_IN_RESERVED = 2'h3;

  // Style field codes, output mode
  localparam logic [1:0] STYLE_OUT_GP_PUSH_PULL = 2'h0;
  localparam logic [1:0] STYLE_OUT_GP_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] STYLE_OUT_AF_PUSH_PULL = 2'h2;
  localparam logic [1:0] STYLE_OUT_AF_OPEN_DRAIN = 2'h3;

  // Freeze key sequence states
  typedef enum logic [3:0] {
    KEY_IDLE = 4'b0001,
    KEY_GOT_ONE = 4'b0010,
    KEY_GOT_ZERO = 4'b0100,
    KEY_GOT_ONE_AGAIN = 4'b1000
  } gpr_key_state_t;

endpackage : gpr_pkg

/* gpr_sync_if.sv */
// Carrier between the register set and its input synchroniser
`timescale 1ns/1ps
interface gpr_sync_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] padLevel;
  logic [WIDTH-1:0] sampled;

  modport syncer (input padLevel, output sampled);
  modport user (output padLevel, input sampled);
endinterface : gpr_sync_if

/* gpr_top.sv */
// Sixteen-pin port register set with APB slave, atomic set/clear and configuration freeze
`timescale 1ns/1ps
module gpr_top #(
  parameter int PIN_COUNT = 16,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [15:0] padIn,
  output logic [15:0] padOut,
  output logic [15:0] padOutEn,
  // Configuration seen by the pad cells
  output logic [15:0] pinOutputBit,
  output logic [63:0] pinConfig,
  output logic freezeActive
);

  if (PIN_COUNT != 16) begin : g_pinCountCheck
    $error("gpr_top register layout serves exactly sixteen pins");
  end
  if (SYNC_STAGES < 2) begin : g_stageCheck
    $error("gpr_top needs at least two synchroniser stages");
  end

  // Input synchroniser
  gpr_sync_if #(.WIDTH(16)) syncBus ();

  assign syncBus.padLevel = padIn;

  gpr_input_sync #(
    .WIDTH(16),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .sync(syncBus.syncer)
  );

  // Bus phase decode
  logic setupPhase;
  logic accessWrite;
  logic accessRead;
  logic [4:0] wordAddr;
  logic addrMapped;
  logic highAddrZero;

  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pready && pwrite;
  assign accessRead = psel && penable && pready && !pwrite;
  assign highAddrZero = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign wordAddr = paddr[4:0];

  always_comb begin
    addrMapped = 1'b0;
    if (highAddrZero) begin
      case (wordAddr)
        gpr_pkg::OFS_CONFIG_LOW,
        gpr_pkg::OFS_CONFIG_HIGH,
        gpr_pkg::OFS_INPUT_SAMPLE,
        gpr_pkg::OFS_OUTPUT_LATCH,
        gpr_pkg::OFS_ATOMIC_SET_CLEAR,
        gpr_pkg::OFS_ATOMIC_CLEAR,
        gpr_pkg::OFS_CONFIG_FREEZE: begin
          addrMapped = 1'b1;
        end
        default: begin
          addrMapped = 1'b0;
        end
      endcase
    end
  end

  // Register state
  logic [31:0] configLow_reg;
  logic [31:0] configLow_next;
  logic [31:0] configHigh_reg;
  logic [31:0] configHigh_next;
  logic [15:0] outputLatch_reg;
  logic [15:0] outputLatch_next;
  logic [15:0] freezeBits_reg;
  logic [15:0] freezeBits_next;
  logic freezeKey_reg;
  logic freezeKey_next;
  gpr_pkg::gpr_key_state_t keyState_reg;
  gpr_pkg::gpr_key_state_t keyState_next;

  // Nibble write masks, cleared where the pin is frozen
  logic [31:0] lowMask;
  logic [31:0] highMask;

  always_comb begin
    lowMask = '0;
    highMask = '0;
    for (int i = 0; i < 8; i++) begin
      lowMask[i*gpr_pkg::NIBBLE_W +: gpr_pkg::NIBBLE_W] = {4{~(freezeKey_reg & freezeBits_reg[i])}};
      highMask[i*gpr_pkg::NIBBLE_W +: gpr_pkg::NIBBLE_W] = {4{~(freezeKey_reg & freezeBits_reg[i+8])}};
    end
  end

  // Configuration registers
  always_comb begin
    configLow_next = configLow_reg;
    configHigh_next = configHigh_reg;
    if (accessWrite && addrMapped && wordAddr == gpr_pkg::OFS_CONFIG_LOW) begin
      configLow_next = (configLow_reg & ~lowMask) | (pwdata & lowMask);
    end
    if (accessWrite && addrMapped && wordAddr == gpr_pkg::OFS_CONFIG_HIGH) begin
      configHigh_next = (configHigh_reg & ~highMask) | (pwdata & highMask);
    end
  end

  // Output latch with atomic set and clear
  logic [15:0] setReq;
  logic [15:0] clearReq;

  assign setReq = pwdata[15:0];
  assign clearReq = pwdata[gpr_pkg::CLEAR_REQ_LSB +: 16];

  always_comb begin
    outputLatch_next = outputLatch_reg;
    if (accessWrite && addrMapped) begin
      case (wordAddr)
        gpr_pkg::OFS_OUTPUT_LATCH: begin
          outputLatch_next = pwdata[15:0];
        end
        gpr_pkg::OFS_ATOMIC_SET_CLEAR: begin
          outputLatch_next = (outputLatch_reg & ~clearReq) | setReq;
        end
        gpr_pkg::OFS_ATOMIC_CLEAR: begin
          outputLatch_next = outputLatch_reg & ~pwdata[15:0];
        end
        default: begin
          outputLatch_next = outputLatch_reg;
        end
      endcase
    end
  end

  // Freeze register and key sequence
  logic freezeWrite;
  logic freezeRead;
  logic keyBitIn;
  logic bitsSame;

  assign freezeWrite = accessWrite && addrMapped && wordAddr == gpr_pkg::OFS_CONFIG_FREEZE;
  assign freezeRead = accessRead && addrMapped && wordAddr == gpr_pkg::OFS_CONFIG_FREEZE;
  assign keyBitIn = pwdata[gpr_pkg::FREEZE_KEY_BIT];
  assign bitsSame = pwdata[15:0] == freezeBits_reg;

  always_comb begin
    freezeBits_next = freezeBits_reg;
    freezeKey_next = freezeKey_reg;
    keyState_next = keyState_reg;
    if (!freezeKey_reg) begin
      if (freezeWrite) begin
        freezeBits_next = pwdata[15:0];
        case (keyState_reg)
          gpr_pkg::KEY_IDLE: begin
            keyState_next = keyBitIn ? gpr_pkg::KEY_GOT_ONE : gpr_pkg::KEY_IDLE;
          end
          gpr_pkg::KEY_GOT_ONE: begin
            if (!keyBitIn && bitsSame) begin
              keyState_next = gpr_pkg::KEY_GOT_ZERO;
            end else begin
              keyState_next = keyBitIn ? gpr_pkg::KEY_GOT_ONE : gpr_pkg::KEY_IDLE;
            end
          end
          gpr_pkg::KEY_GOT_ZERO: begin
            if (keyBitIn && bitsSame) begin
              keyState_next = gpr_pkg::KEY_GOT_ONE_AGAIN;
            end else begin
              keyState_next = keyBitIn ? gpr_pkg::KEY_GOT_ONE : gpr_pkg::KEY_IDLE;
            end
          end
          gpr_pkg::KEY_GOT_ONE_AGAIN: begin
            keyState_next = keyBitIn ? gpr_pkg::KEY_GOT_ONE : gpr_pkg::KEY_IDLE;
          end
          default: begin
            keyState_next = gpr_pkg::KEY_IDLE;
          end
        endcase
      end else if (freezeRead) begin
        if (keyState_reg == gpr_pkg::KEY_GOT_ONE_AGAIN) begin
          freezeKey_next = 1'b1;
        end
        keyState_next = gpr_pkg::KEY_IDLE;
      end
    end
  end

  // Read data, ready and error, prepared in the setup cycle
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;

  always_comb begin
    prdata_next = '0;
    pready_next = setupPhase;
    pslverr_next = setupPhase && !addrMapped;
    if (setupPhase && !pwrite && addrMapped) begin
      case (wordAddr)
        gpr_pkg::OFS_CONFIG_LOW: begin
          prdata_next = configLow_reg;
        end
        gpr_pkg::OFS_CONFIG_HIGH: begin
          prdata_next = configHigh_reg;
        end
        gpr_pkg::OFS_INPUT_SAMPLE: begin
          prdata_next = {16'h0000, syncBus.sampled};
        end
        gpr_pkg::OFS_OUTPUT_LATCH: begin
          prdata_next = {16'h0000, outputLatch_reg};
        end
        gpr_pkg::OFS_CONFIG_FREEZE: begin
          prdata_next = {15'h0000, freezeKey_reg, freezeBits_reg};
        end
        default: begin
          prdata_next = '0;
        end
      endcase
    end
  end

  // Pad drive, derived from the next configuration and latch
  logic [15:0] padOut_next;
  logic [15:0] padOutEn_next;
  logic [63:0] configAll_next;

  assign configAll_next = {configHigh_next, configLow_next};

  always_comb begin
    padOut_next = outputLatch_next;
    padOutEn_next = '0;
    for (int i = 0; i < 16; i++) begin
      if (configAll_next[i*4+gpr_pkg::DIR_SPEED_LSB +: 2] != gpr_pkg::DIR_INPUT) begin
        case (configAll_next[i*4+gpr_pkg::STYLE_LSB +: 2])
          gpr_pkg::STYLE_OUT_GP_PUSH_PULL: begin
            padOutEn_next[i] = 1'b1;
          end
          gpr_pkg::STYLE_OUT_GP_OPEN_DRAIN: begin
            padOutEn_next[i] = !outputLatch_next[i];
          end
          default: begin
            padOutEn_next[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // Configuration state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      configLow_reg <= gpr_pkg::RST_CONFIG_LOW;
      configHigh_reg <= gpr_pkg::RST_CONFIG_HIGH;
    end else begin
      configLow_reg <= configLow_next;
      configHigh_reg <= configHigh_next;
    end
  end

  // Output latch state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outputLatch_reg <= gpr_pkg::RST_OUTPUT_LATCH;
    end else begin
      outputLatch_reg <= outputLatch_next;
    end
  end

  // Freeze state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freezeBits_reg <= gpr_pkg::RST_FREEZE_BITS;
      freezeKey_reg <= 1'b0;
      keyState_reg <= gpr_pkg::KEY_IDLE;
    end else begin
      freezeBits_reg <= freezeBits_next;
      freezeKey_reg <= freezeKey_next;
      keyState_reg <= keyState_next;
    end
  end

  // Bus response state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // Pad drive state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padOut <= '0;
      padOutEn <= '0;
    end else begin
      padOut <= padOut_next;
      padOutEn <= padOutEn_next;
    end
  end

  assign pinOutputBit = outputLatch_reg;
  assign pinConfig = {configHigh_reg, configLow_reg};
  assign freezeActive = freezeKey_reg;

endmodule : gpr_top

/* gpr_top_asserts.sv */
// Concurrent checks on the port register set boundary
`timescale 1ns/1ps
module gpr_top_asserts #(
  parameter int PIN_COUNT = 16,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin state
  input wire logic [15:0] pinOutputBit,
  input wire logic [63:0] pinConfig,
  input wire logic freezeActive
);
  logic [31:0] wdPrev_reg;
  logic [31:0] cfgPrev_reg;
  logic keyRdPrev_reg;
  logic wrSet;
  logic wrClr;
  assign wrSet = psel && penable && pready && pwrite && paddr == 12'h010;
  assign wrClr = psel && penable && pready && pwrite && paddr == 12'h014;
  always_ff @(posedge clk) begin
    wdPrev_reg <= pwdata;
    cfgPrev_reg <= pinConfig[31:0];
    keyRdPrev_reg <= psel && penable && !pwrite && paddr == 12'h018;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pready |-> pslverr == (paddr[11:5] != 0 || paddr[1:0] != 0 || paddr[4:2] == 3'h7); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_set; wrSet |=> (pinOutputBit & wdPrev_reg[15:0]) == wdPrev_reg[15:0]; endproperty
  a_set: assert property (p_set) else $error("set request lost");
  property p_clrHi; wrSet |=> (pinOutputBit & wdPrev_reg[31:16] & ~wdPrev_reg[15:0]) == 16'h0000; endproperty
  a_clrHi: assert property (p_clrHi) else $error("clear request lost");
  property p_clr; wrClr |=> (pinOutputBit & wdPrev_reg[15:0]) == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("clear register ignored");
  property p_hold; !(psel && penable && pwrite) |=> $stable(pinOutputBit); endproperty
  a_hold: assert property (p_hold) else $error("latch moved without write");
  property p_latRd; pready && !pwrite && paddr == 12'h00C |-> prdata == {16'h0000, $past(pinOutputBit)}; endproperty
  a_latRd: assert property (p_latRd) else $error("latch read wrong");
  property p_cfgRd; pready && !pwrite && paddr == 12'h000 |-> prdata == cfgPrev_reg; endproperty
  a_cfgRd: assert property (p_cfgRd) else $error("config low read wrong");
  property p_keep; freezeActive |=> freezeActive; endproperty
  a_keep: assert property (p_keep) else $error("freeze released");
  property p_rise; $rose(freezeActive) |-> keyRdPrev_reg; endproperty
  a_rise: assert property (p_rise) else $error("freeze without key read");
endmodule : gpr_top_asserts
bind gpr_top gpr_top_asserts #(.PIN_COUNT(PIN_COUNT), .SYNC_STAGES(SYNC_STAGES)) chk_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinOutputBit(pinOutputBit),
  .pinConfig(pinConfig), .freezeActive(freezeActive)
);

/* tb_top.sv */
// Self-checking bench for the port register set
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] padIn = 16'h0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] padOut;
  logic [15:0] padOutEn;
  logic [15:0] pinOutputBit;
  logic [63:0] pinConfig;
  logic freezeActive;
  logic [31:0] rnd = 32'h0001_1CC5;
  logic [31:0] w;
  logic [31:0] q;
  logic e;
  logic [15:0] lat = 16'h0000;
  int numErrors = 0;
  int nTests = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  gpr_top dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut),
    .padOutEn(padOutEn), .pinOutputBit(pinOutputBit), .pinConfig(pinConfig), .freezeActive(freezeActive)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr

  function automatic logic oeExp(input logic [3:0] nib, input logic lb);
    if (nib[1:0] == 2'h0) return 1'b0;
    if (nib[3:2] == 2'h0) return 1'b1;
    if (nib[3:2] == 2'h1) return ~lb;
    return 1'b0;
  endfunction : oeExp

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      $display("MISMATCH at %0t: timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h000, 32'h4444_4444);
    rd(12'h004, 32'h4444_4444);
    rd(12'h00C, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    rd(12'h014, 32'h0000_0000);
    rd(12'h018, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      w = (i == 1) ? 32'hFFFF_FFFF : rnd;
      case (i % 3)
        0: begin
          apb(1'b1, 12'h00C, w);
          lat = w[15:0];
        end
        1: begin
          apb(1'b1, 12'h010, w);
          lat = (lat & ~w[31:16]) | w[15:0];
        end
        default: begin
          apb(1'b1, 12'h014, w);
          lat = lat & ~w[15:0];
        end
      endcase
      rd(12'h00C, {16'h0000, lat});
      chk({16'h0000, padOut}, {16'h0000, lat});
    end
    $display("latch traffic done");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h004, {8{c[3:0]}});
      rd(12'h004, {8{c[3:0]}});
      chk(pinConfig[63:32], {8{c[3:0]}});
      chk({31'h0000_0000, padOutEn[8]}, {31'h0000_0000, oeExp(c[3:0], lat[8])});
    end
    $display("config codes done");
    rnd = lfsr(rnd);
    padIn <= rnd[15:0];
    repeat (3) @(posedge clk);
    rd(12'h008, {16'h0000, rnd[15:0]});
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    rd(12'h008, {16'h0000, rnd[15:0]});
    $display("input sample done");
    apb(1'b1, 12'h018, 32'h0001_00F0);
    apb(1'b1, 12'h018, 32'h0000_000F);
    apb(1'b1, 12'h018, 32'h0001_000F);
    rd(12'h018, 32'h0000_000F);
    apb(1'b1, 12'h018, 32'h0001_00F0);
    apb(1'b1, 12'h018, 32'h0000_00F0);
    apb(1'b1, 12'h018, 32'h0001_00F0);
    rd(12'h018, 32'h0000_00F0);
    rd(12'h018, 32'h0001_00F0);
    chk({31'h0000_0000, freezeActive}, 32'h0000_0001);
    apb(1'b1, 12'h018, 32'h0000_0000);
    rd(12'h018, 32'h0001_00F0);
    apb(1'b1, 12'h000, 32'h3333_3333);
    rd(12'h000, 32'h4444_3333);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h018, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h3333_3333);
    rd(12'h000, 32'h3333_3333);
    $display("freeze sequence done");
    report_and_stop();
  end
endmodule : tb_top
